// ===== hdl/jbsp_regs.svh
// jbsp_regs.svh: constants of the boundary-scan test port
// assumes: included by the package and the design file by bare name
`ifndef JBSP_REGS_SVH
`define JBSP_REGS_SVH

`define JBSP_IR_WIDTH     4
`define JBSP_IR_RESET     4'h1
`define JBSP_BUS_WIDTH    64
`define JBSP_HALF_WIDTH   32
`define JBSP_OP_EXTEST    4'h0
`define JBSP_OP_SAMPLE    4'h2
`define JBSP_OP_BYPASS    4'hf

`endif

// ===== hdl/jbsp_pkg.sv
// jbsp_pkg.sv: types shared by the boundary-scan test port
// assumes: constants come from jbsp_regs.svh
`include "jbsp_regs.svh"

package jbsp_pkg;

    // standard sixteen-state test access controller
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jbsp_state_t;

    // serial test pins as driven by the device
    typedef struct packed {
        logic data;
        logic oe;
    } jbsp_tdo_t;

endpackage

// ===== hdl/jbsp_tap.sv
// jbsp_tap.sv: boundary-scan test access port over the system address/data bus
// assumes: test pins are asynchronous to clk; test clock is far slower than clk
// Functional notes
// - rising test clock shifts input into IR/DR
// - serial output changes on falling test clock
// - serial output released when nothing shifts
// - test logic timed only by test clock; here all flops run on clk and act on sampled test clock edges
// - mode select sampled on rising edge
// - controller decodes mode select into states
// - active-low test reset, asynchronous, core-independent; here sampled through clk, and sys_rst also resets the port
// - test reset low releases serial output
// - width strap: low 32 bits, high 64
// - enable strap open holds controller reset
// - enable strap high: test reset governs
// - chain built from system address/data bus
`timescale 1ns/1ps
`default_nettype none
`include "jbsp_regs.svh"

module jbsp_tap
    import jbsp_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // test pins
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    input  wire logic                       trst_n,
    output logic                            tdo_o,
    output logic                            tdo_oe,
    // straps, pulled low outside when open
    input  wire logic                       scan_width_select,
    input  wire logic                       tap_reset_release_strap,
    // boundary cells on the system address/data bus
    input  wire logic [`JBSP_BUS_WIDTH-1:0] system_addr_data_bus_in,
    output logic [`JBSP_BUS_WIDTH-1:0]      system_addr_data_bus_out,
    output logic                            bscan_extest
);

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every asynchronous pin
    // reset value 0 reads as test reset held, so the port wakes quiet
    // the bus word is only used at capture, long after its levels settle
    logic [5:0]                 s1_ff;
    logic [5:0]                 s2_ff;
    logic                       tck_d_ff;
    logic [`JBSP_BUS_WIDTH-1:0] bus_s1_ff;
    logic [`JBSP_BUS_WIDTH-1:0] bus_s2_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff     <= 6'h00;
            s2_ff     <= 6'h00;
            tck_d_ff  <= 1'b0;
            bus_s1_ff <= 64'h0;
            bus_s2_ff <= 64'h0;
        end else begin
            s1_ff     <= {tck, tms, tdi, trst_n, scan_width_select, tap_reset_release_strap};
            s2_ff     <= s1_ff;
            tck_d_ff  <= s2_ff[5];
            bus_s1_ff <= system_addr_data_bus_in;
            bus_s2_ff <= bus_s1_ff;
        end
    end

    wire tck_s    = s2_ff[5];
    wire tms_s    = s2_ff[4];
    wire tdi_s    = s2_ff[3];
    wire trst_n_s = s2_ff[2];
    wire wide_s   = s2_ff[1];
    wire rel_s    = s2_ff[0];

    // all test state advances only on detected test clock edges
    wire tck_rise = tck_s & ~tck_d_ff;
    wire tck_fall = ~tck_s & tck_d_ff;
    // open enable strap reads low and holds reset regardless of test reset
    wire tap_rst  = ~rel_s | ~trst_n_s;
    // an open width strap reads low, so the short chain is the safe default

    ////////////////////////////////////////////////////////////////////////////
    // next-state decode of the controller
    function automatic jbsp_state_t next_state(input jbsp_state_t s, input logic m);
        case (s)
            ST_RESET:  next_state = m ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = m ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = m ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    endfunction

    jbsp_state_t state_ff;
    jbsp_state_t nxt_state;
    assign nxt_state = next_state(state_ff, tms_s);

    ////////////////////////////////////////////////////////////////////////////
    // registers of the port
    logic [`JBSP_IR_WIDTH-1:0]  ir_sh_ff;
    logic [`JBSP_IR_WIDTH-1:0]  ir_ff;
    logic [`JBSP_BUS_WIDTH-1:0] bs_sh_ff;
    logic [`JBSP_BUS_WIDTH-1:0] bs_upd_ff;
    logic                       byp_ff;

    wire sel_bs = (ir_ff == `JBSP_OP_EXTEST) || (ir_ff == `JBSP_OP_SAMPLE);
    // top shift position depends on chain length; bits above are out of the chain
    wire [`JBSP_BUS_WIDTH-1:0] bs_shifted = wide_s
        ? {tdi_s, bs_sh_ff[`JBSP_BUS_WIDTH-1:1]}
        : {32'h0000_0000, tdi_s, bs_sh_ff[`JBSP_HALF_WIDTH-1:1]};
    wire [`JBSP_BUS_WIDTH-1:0] bus_cap = wide_s ? bus_s2_ff
        : {32'h0000_0000, bus_s2_ff[`JBSP_HALF_WIDTH-1:0]};

    // either reset source parks the controller in test-logic-reset
    // a held reset also swallows every test clock edge, so no half step survives
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_RESET;
        end else if (tap_rst) begin
            state_ff <= ST_RESET;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // shift and capture on rising edges
    // bypass cell is cleared at capture so a data shift first reads zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_sh_ff <= `JBSP_IR_RESET;
            bs_sh_ff <= 64'h0;
            byp_ff   <= 1'b0;
        end else if (tck_rise) begin
            case (state_ff)
                ST_CAP_IR: ir_sh_ff <= `JBSP_IR_RESET;
                ST_SH_IR:  ir_sh_ff <= {tdi_s, ir_sh_ff[`JBSP_IR_WIDTH-1:1]};
                ST_CAP_DR: begin
                    bs_sh_ff <= bus_cap;
                    byp_ff   <= 1'b0;
                end
                ST_SH_DR: begin
                    if (sel_bs) bs_sh_ff <= bs_shifted;
                    else byp_ff <= tdi_s;
                end
                default: ;
            endcase
        end
    end

    // instruction and bus update; bypass after test reset
    // update acts at the fall so the new word is settled half a test clock
    // before the next rise can use it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_ff     <= `JBSP_OP_BYPASS;
            bs_upd_ff <= 64'h0;
        end else if (state_ff == ST_RESET) begin
            ir_ff     <= `JBSP_OP_BYPASS;
        end else if (tck_fall && state_ff == ST_UPD_IR) begin
            ir_ff     <= ir_sh_ff;
        end else if (tck_fall && state_ff == ST_UPD_DR && sel_bs) begin
            bs_upd_ff <= bs_sh_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial output: data and enable change on falling edge
    wire        shifting = (state_ff == ST_SH_IR) || (state_ff == ST_SH_DR);
    wire        out_bit  = (state_ff == ST_SH_IR) ? ir_sh_ff[0]
                         : (sel_bs ? bs_sh_ff[0] : byp_ff);
    jbsp_tdo_t  tdo_ff;

    // enable follows the state entered at the last rise, so it rises half a
    // test clock into a shift state and drops half a test clock after it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdo_ff <= '{data: 1'b0, oe: 1'b0};
        end else if (tap_rst) begin
            tdo_ff <= '{data: 1'b0, oe: 1'b0};
        end else if (tck_fall) begin
            tdo_ff <= '{data: out_bit, oe: shifting};
        end
    end

    // bus-side boundary outputs, registered
    // the external test level drops at once under test reset, ahead of the
    // instruction falling back to bypass
    logic [`JBSP_BUS_WIDTH-1:0] bus_out_ff;
    logic                       extest_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_out_ff <= 64'h0;
            extest_ff  <= 1'b0;
        end else begin
            bus_out_ff <= bs_upd_ff;
            extest_ff  <= (ir_ff == `JBSP_OP_EXTEST) && !tap_rst;
        end
    end

    assign tdo_o                    = tdo_ff.data;
    assign tdo_oe                   = tdo_ff.oe;
    assign system_addr_data_bus_out = bus_out_ff;
    assign bscan_extest             = extest_ff;

endmodule

`default_nettype wire

// ===== verif/jbsp_tap_assertions.sv
// jbsp_tap_assertions.sv: port-level checker of the boundary-scan test port
// assumes: bench moves test reset and straps only while the test clock stands low
`timescale 1ns/1ps
`default_nettype none
module jbsp_tap_assertions (
    // clock, reset and test pins
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        tck,
    input wire logic        trst_n,
    input wire logic        tdo_o,
    input wire logic        tdo_oe,
    // straps and boundary side
    input wire logic        scan_width_select,
    input wire logic        tap_reset_release_strap,
    input wire logic [63:0] system_addr_data_bus_out,
    input wire logic        bscan_extest
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // five cycles cover the pin synchroniser plus the output register
    trst_hold_off_a: assert property ((!trst_n)[*5] |-> !tdo_oe)
        else $error("tdo driven during test reset");
    strap_hold_off_a: assert property ((!tap_reset_release_strap)[*5] |-> !tdo_oe)
        else $error("tdo driven with release strap low");
    trst_bypass_a: assert property ((!trst_n)[*6] |-> !bscan_extest)
        else $error("extest kept during test reset");
    tdo_at_fall_a: assert property ($changed(tdo_o) |-> !$past(tck))
        else $error("tdo moved outside a low test clock");
    oe_at_fall_a: assert property ($rose(tdo_oe) |-> !$past(tck))
        else $error("tdo enable rose outside a low test clock");
    tdo_high_hold_a: assert property (tck && $past(tck) |-> $stable(tdo_o) && $stable(tdo_oe))
        else $error("tdo changed while test clock high");
    upper_zero_a: assert property ($changed(system_addr_data_bus_out) && !scan_width_select
        |-> system_addr_data_bus_out[63:32] == 32'h0)
        else $error("upper cells updated in 32-bit mode");
    upd_released_a: assert property ($changed(system_addr_data_bus_out)
        |-> trst_n && tap_reset_release_strap)
        else $error("boundary update while held in reset");
endmodule
bind jbsp_tap jbsp_tap_assertions jbsp_tap_assertions_i (.clk(clk), .sys_rst(sys_rst),
    .tck(tck), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .scan_width_select(scan_width_select), .tap_reset_release_strap(tap_reset_release_strap),
    .system_addr_data_bus_out(system_addr_data_bus_out), .bscan_extest(bscan_extest));
`default_nettype wire

// ===== verif/jbsp_tester.sv
// jbsp_tester.sv: model of the external test controller driving the test pins
// assumes: clk is the 5 ns bench clock; test clock of 80 ns stands low between steps
`timescale 1ns/1ps
`default_nettype none
module jbsp_tester (
    // bench clock and resolved serial output line
    input wire logic  clk,
    input wire logic  tdo_w,
    // test pins and the bit seen at each rising test clock
    output var logic  tck,
    output var logic  tms,
    output var logic  tdi,
    output var logic  smp,
    output var logic  smp_v
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        smp = 1'b0;
        smp_v = 1'b0;
    end
    // one test clock: mode and data set while low, held across the rise
    task automatic step(input logic m, input logic d, input logic chk);
        @(posedge clk);
        #1 tms = m;
        tdi = d;
        repeat (7) @(posedge clk);
        #1 tck = 1'b1;
        smp = tdo_w;
        smp_v = chk;
        @(posedge clk);
        #1 smp_v = 1'b0;
        repeat (7) @(posedge clk);
        #1 tck = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// tb.sv: self-checking bench of the boundary-scan test port
// assumes: tester model drives the test pins; tdo line has no pull
`timescale 1ns/1ps
`default_nettype none
`include "jbsp_regs.svh"
module tb;
    import jbsp_pkg::*;
    logic        clk = 0, sys_rst = 1, trst_n = 0, wsel = 1, rel = 1, tdo_last = 0;
    logic        tdo_o, tdo_oe, ext, tck, tms, tdi, smp, smp_v;
    logic [63:0] bus_in, bus_out, d;
    logic        q[$];
    int          err_total = 0, tests_run = 0, seed = 32'h43dc;
    // a released line shows the inverse of its last value, never a settled guess
    wire tdo_w = tdo_oe ? tdo_o : ~tdo_last;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (tdo_oe) tdo_last <= tdo_o;
    jbsp_tap jbsp_tap_i (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .scan_width_select(wsel),
        .tap_reset_release_strap(rel), .system_addr_data_bus_in(bus_in),
        .system_addr_data_bus_out(bus_out), .bscan_extest(ext));
    jbsp_tester jbsp_tester_i (.clk(clk), .tdo_w(tdo_w), .tck(tck), .tms(tms), .tdi(tdi),
        .smp(smp), .smp_v(smp_v));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [7:0] ms, input int n); // tms bits, first bit lowest
        for (int i = 0; i < n; i++) jbsp_tester_i.step(ms[i], 1'b0, 1'b0);
    endtask
    // shift n bits, leave through update to idle, then let the update land
    task automatic shift(input logic [63:0] din, input logic [63:0] exp, input int n);
        for (int i = 0; i < n; i++) begin
            q.push_back(exp[i]);
            jbsp_tester_i.step(i == n - 1, din[i], 1'b1);
        end
        go(8'h01, 2);
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic ir(input logic [3:0] op);
        go(8'h03, 4);
        shift({60'h0, op}, 64'h1, 4);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watcher: each sampled serial bit against the oldest noted value
    always @(posedge clk) if (smp_v) begin
        if (q.size() == 0) chk(1'b1, 1'b0);
        else chk(smp, q.pop_front());
    end
    initial begin
        #100000 err_total++;
        end_sim();
    end
    initial begin
        bus_in = {$random(seed), $random(seed)};
        repeat (16) @(posedge clk);
        #1 sys_rst = 0;
        repeat (6) @(posedge clk);
        #1 chk(tdo_oe, 0);
        trst_n = 1;
        go(8'h1f, 6);
        ir(`JBSP_OP_EXTEST);
        d = {$random(seed), $random(seed)};
        shift_dr: begin
            go(8'h01, 3);
            shift(d, bus_in, 64);
        end
        chk(bus_out, d);
        chk(ext, 1);
        chk(tdo_oe, 0);
        wsel = 0;
        bus_in = {$random(seed), $random(seed)};
        d = {$random(seed), $random(seed)};
        go(8'h01, 3);
        shift(d, {32'h0, bus_in[31:0]}, 32);
        chk(bus_out, {32'h0, d[31:0]});
        ir(`JBSP_OP_BYPASS);
        go(8'h01, 3);
        shift(d, {d[6:0], 1'b0}, 8);
        chk(ext, 0);
        ir(`JBSP_OP_EXTEST);
        go(8'h01, 3);
        trst_n = 0; // abort in shift-DR
        repeat (8) @(posedge clk);
        #1 chk(tdo_oe, 0);
        chk(ext, 0);
        trst_n = 1;
        go(8'h00, 1);
        chk(ext, 0);
        ir(`JBSP_OP_SAMPLE);
        bus_in = {$random(seed), $random(seed)};
        d = {$random(seed), $random(seed)};
        go(8'h01, 3);
        shift(d, {32'h0, bus_in[31:0]}, 32);
        chk(bus_out, {32'h0, d[31:0]});
        chk(ext, 0);
        rel = 0;
        go(8'h03, 4);
        repeat (8) @(posedge clk);
        #1 chk(tdo_oe, 0);
        rel = 1;
        go(8'h1f, 6);
        ir(`JBSP_OP_BYPASS);
        end_sim();
    end
endmodule
`default_nettype wire
